// file: bench/nfc_flash_model.sv
// behavioural two-district flash device for the bench
`timescale 1ns/1ps
module nfc_flash_model #(
	parameter [7:0] MAKER_ID = 8'h3c, // arbitrary value
	parameter [7:0] PART_ID  = 8'h5a, // arbitrary value
	parameter [1:0] CHIPS    = 2'b00,
	parameter [1:0] CELLS    = 2'b00,
	parameter [1:0] PAGE_SZ  = 2'b01,
	parameter [1:0] BLOCK_SZ = 2'b01,
	parameter       WIDE     = 1'b0,
	parameter [1:0] DISTS    = 2'b01
)(
	input  wire        nand_ce_n,
	input  wire        nand_cle,
	input  wire        nand_ale,
	input  wire        nand_we_n,
	input  wire        read_strobe_n,
	input  wire        nand_wp_n,
	input  wire  [7:0] nand_io_out,
	output logic [7:0] nand_io_in,
	output logic       ready_busy_output
);
	// ****************
	// device behaviour
	// ****************
	logic [63:0] cmd_hist = 64'h0;
	logic [7:0]  n_addr = 8'h0;
	logic [7:0]  n_data = 8'h0;
	logic [7:0]  rd_byte;
	logic [1:0]  fail_d = 2'b00;
	logic        st_mode = 1'b0;
	logic [2:0]  idx = 3'h0;
	int          busy_ns = 100;
	initial
	begin
		nand_io_in = 8'h00;
		ready_busy_output = 1'b1;
	end
	task clr();
	begin
		cmd_hist = 64'h0;
		n_addr = 8'h0;
		n_data = 8'h0;
	end
	endtask
	always @(posedge nand_we_n)
		if (!nand_ce_n && nand_cle)
		begin
			cmd_hist = {cmd_hist[55:0], nand_io_out};
			st_mode = (nand_io_out == 8'h71);
			idx = 3'h0;
			case (nand_io_out)
			8'h11, 8'h15, 8'h10, 8'hd0, 8'hff:
			begin
				ready_busy_output = 1'b0;
				ready_busy_output <= #(busy_ns) 1'b1;
			end
			default: ;
			endcase
		end
		else if (!nand_ce_n && nand_ale)
			n_addr = n_addr + 8'h1;
		else if (!nand_ce_n)
			n_data = n_data + 8'h1;
	always @*
		if (st_mode)
			rd_byte = {nand_wp_n, 1'b1, ready_busy_output,
				fail_d, fail_d, |fail_d};
		else
			case (idx)
			3'h0: rd_byte = MAKER_ID;
			3'h1: rd_byte = PART_ID;
			3'h2: rd_byte = {4'b1001, CELLS, CHIPS};
			3'h3: rd_byte = {1'b0, WIDE, BLOCK_SZ, 2'b01, PAGE_SZ};
			default: rd_byte = {4'b0111, DISTS, 2'b10};
			endcase
	always @(negedge read_strobe_n)
		nand_io_in = rd_byte;
	always @(posedge read_strobe_n)
	begin
		nand_io_in = ~nand_io_in;
		idx = idx + 3'h1;
	end
endmodule

// file: bench/nfc_host_props.sv
// pin assertions for the nand host sequencer
`timescale 1ns/1ps
module nfc_hp_props (
	input wire       clock,
	input wire       rstn,
	input wire       nand_ce_n,
	input wire       nand_cle,
	input wire       nand_ale,
	input wire       nand_we_n,
	input wire       read_strobe_n,
	input wire       nand_wp_n,
	input wire [7:0] nand_io_out,
	input wire       nand_io_oe,
	input wire       ready_busy_output
);
	// ****************
	// pin checks
	// ****************
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	a_latch_excl: assert property (!(nand_cle && nand_ale))
		else $error("cle and ale high together");
	a_we_width: assert property ($fell(nand_we_n) |->
		!nand_we_n [*5] ##1 nand_we_n)
		else $error("write strobe width wrong");
	a_io_driven: assert property (!nand_we_n |->
		nand_io_oe && !nand_ce_n)
		else $error("io not driven in write strobe");
	a_io_stable: assert property (!nand_we_n && $past(!nand_we_n) |->
		$stable(nand_io_out) && $stable(nand_cle) && $stable(nand_ale))
		else $error("io moved in write strobe");
	a_read_release: assert property (!read_strobe_n |->
		!nand_io_oe && !nand_ce_n)
		else $error("io driven in read strobe");
	a_read_excl: assert property (!read_strobe_n |-> nand_we_n)
		else $error("read and write strobes together");
	a_wp_copy: assert property (nand_cle && !nand_we_n &&
		nand_io_out == 8'h8c |-> nand_wp_n)
		else $error("write protect low in copy");
	a_cmd_ready: assert property ($fell(nand_we_n) && nand_cle |->
		$past(ready_busy_output, 1) && $past(ready_busy_output, 2))
		else $error("command while device busy");
endmodule
bind nfc_host nfc_hp_props u_props (
	.clock(clock), .rstn(rstn), .nand_ce_n(nand_ce_n),
	.nand_cle(nand_cle), .nand_ale(nand_ale), .nand_we_n(nand_we_n),
	.read_strobe_n(read_strobe_n), .nand_wp_n(nand_wp_n),
	.nand_io_out(nand_io_out), .nand_io_oe(nand_io_oe),
	.ready_busy_output(ready_busy_output));

// file: bench/nfc_host_test.sv
// self-checking bench for the nand host sequencer
`timescale 1ns/1ps
`include "nfc_defines.vh"
module nfc_host_test;
	// ****************
	// bench
	// ****************
	logic        clock = 1'b0;
	logic        rstn = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	wire  [31:0] rdata;
	wire         ce_n, cle, ale, we_n, rds_n, wp_n, oe, rb;
	wire  [7:0]  io_out, io_dev, io_bus;
	logic [31:0] rv;
	int          err_count = 0;
	int          check_count = 0;
	assign io_bus = oe ? io_out : io_dev;
	always #2.5 clock = ~clock;
	nfc_host dut (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .nand_ce_n(ce_n), .nand_cle(cle),
		.nand_ale(ale), .nand_we_n(we_n), .read_strobe_n(rds_n),
		.nand_wp_n(wp_n), .nand_io_out(io_out), .nand_io_oe(oe),
		.nand_io_in(io_bus), .ready_busy_output(rb));
	nfc_flash_model u_flash (.nand_ce_n(ce_n), .nand_cle(cle),
		.nand_ale(ale), .nand_we_n(we_n), .read_strobe_n(rds_n),
		.nand_wp_n(wp_n), .nand_io_out(io_out), .nand_io_in(io_dev),
		.ready_busy_output(rb));
	task report_and_stop();
	begin
		if (err_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	task check(input string nm, input logic [63:0] seen, exp);
	begin
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	end
	endtask
	task wr_reg(input logic [3:0] a, input logic [31:0] d);
	begin
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	end
	endtask
	task rd_reg(input logic [3:0] a);
	begin
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 rv = rdata;
	end
	endtask
	task wait_clear(input int b);
	int n;
	begin
		n = 0;
		repeat (2) @(posedge clock);
		rd_reg(`NFC_REG_STATUS);
		while (rv[b] !== 1'b0 && n < 3000)
		begin
			rd_reg(`NFC_REG_STATUS);
			n++;
		end
		check("status poll", n < 3000, 1);
	end
	endtask
	task run_op(input logic [31:0] ctrl, input int nb);
	begin
		wr_reg(`NFC_REG_CTRL, ctrl);
		for (int i = 0; i < nb; i++)
		begin
			wr_reg(`NFC_REG_WDATA, 32'ha0 + i);
			wait_clear(5);
		end
		wait_clear(0);
	end
	endtask
	task expect_log(input logic [63:0] cmds, input logic [7:0] na, nd);
	begin
		check("commands", u_flash.cmd_hist, cmds);
		check("addr cycles", u_flash.n_addr, na);
		check("data cycles", u_flash.n_data, nd);
		u_flash.clr();
	end
	endtask
	task t_id();
	begin
		run_op(32'h7, 0);
		expect_log(64'h90, 8'h1, 8'h0);
		rd_reg(`NFC_REG_ID_LO);
		check("id low", rv, 32'h15905a3c);
		rd_reg(`NFC_REG_ID_HI);
		check("id high", rv[7:0], 8'h76);
	end
	endtask
	task t_dual_prog();
	begin
		u_flash.busy_ns = 3000;
		wr_reg(`NFC_REG_ADDR_A, 32'h45);
		wr_reg(`NFC_REG_ADDR_B, 32'h85);
		wr_reg(`NFC_REG_COUNT, 32'h1);
		run_op(32'h2, 2);
		expect_log(64'h8011811571, 8'd10, 8'd2);
		run_op(32'h12, 2);
		expect_log(64'h8011811071, 8'd10, 8'd2);
		rd_reg(`NFC_REG_DSTAT);
		check("dual status", rv[7:0], 8'he0);
		u_flash.busy_ns = 100;
	end
	endtask
	task t_refuse();
		logic [31:0] bad [2];
	begin
		bad = '{32'hc5, 32'h86};
		foreach (bad[i])
		begin
			wr_reg(`NFC_REG_ADDR_A, 32'h45);
			wr_reg(`NFC_REG_ADDR_B, bad[i]);
			run_op(32'h2, 0);
			check("refused err", rv[3], 1'b1);
			expect_log(64'h0, 8'h0, 8'h0);
		end
		run_op(32'h13, 0);
		check("copy refused", rv[3], 1'b1);
		expect_log(64'h0, 8'h0, 8'h0);
	end
	endtask
	task t_copy();
	begin
		wr_reg(`NFC_REG_ADDR_A, 32'h03);
		run_op(32'h33, 1);
		expect_log(64'h8c10, 8'd5, 8'd1);
		run_op(32'h13, 0);
		expect_log(64'h8c10, 8'd5, 8'd0);
		wr_reg(`NFC_REG_ADDR_A, 32'h45);
		run_op(32'h14, 0);
		expect_log(64'h8c118c1071, 8'd10, 8'd0);
		rd_reg(`NFC_REG_DSTAT);
		check("copy status", rv[7:0], 8'he0);
	end
	endtask
	task t_prog();
	begin
		run_op(32'h11, 1);
		expect_log(64'h8010, 8'd5, 8'd1);
	end
	endtask
	task t_erase();
	begin
		run_op(32'h5, 0);
		expect_log(64'h60d0, 8'd3, 8'd0);
		u_flash.fail_d = 2'b10;
		wr_reg(`NFC_REG_ADDR_A, 32'h40);
		wr_reg(`NFC_REG_ADDR_B, 32'h00);
		run_op(32'h6, 0);
		expect_log(64'h6060d071, 8'd6, 8'd0);
		rd_reg(`NFC_REG_DSTAT);
		check("erase status", rv[7:0], 8'hf5);
		u_flash.fail_d = 2'b00;
	end
	endtask
	initial
	begin
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		t_id();
		t_dual_prog();
		t_copy();
		t_prog();
		t_erase();
		t_refuse();
		run_op(32'h8, 0);
		expect_log(64'hff, 8'h0, 8'h0);
		report_and_stop();
	end
	initial
	begin
		#400000;
		err_count++;
		report_and_stop();
	end
endmodule

// file: common/nfc_defines.vh
// constants for the nand program, copy, erase and id sequencer
`ifndef NFC_DEFINES_VH
`define NFC_DEFINES_VH
// commands
`define NFC_CMD_SETUP      8'h80
`define NFC_CMD_SETUP2     8'h81
`define NFC_CMD_MULTI      8'h11
`define NFC_CMD_CACHE      8'h15
`define NFC_CMD_PROG       8'h10
`define NFC_CMD_COPY_TGT   8'h8c
`define NFC_CMD_ERASE      8'h60
`define NFC_CMD_ERASE_GO   8'hd0
`define NFC_CMD_STAT_DIST  8'h71
`define NFC_CMD_ID         8'h90
`define NFC_CMD_RESET      8'hff
`define NFC_CMD_READ       8'h00
`define NFC_CMD_READ_GO    8'h35
// software register offsets
`define NFC_REG_CTRL       4'h0
`define NFC_REG_ADDR_A     4'h1
`define NFC_REG_ADDR_B     4'h2
`define NFC_REG_WDATA      4'h3
`define NFC_REG_STATUS     4'h4
`define NFC_REG_RDATA      4'h5
`define NFC_REG_ID_LO      4'h6
`define NFC_REG_ID_HI      4'h7
`define NFC_REG_DSTAT      4'h8
`define NFC_REG_COUNT      4'h9
// operation codes in ctrl[3:0]
`define NFC_OP_PROG        4'h1
`define NFC_OP_DUAL_PROG   4'h2
`define NFC_OP_COPY        4'h3
`define NFC_OP_DUAL_COPY   4'h4
`define NFC_OP_ERASE       4'h5
`define NFC_OP_DUAL_ERASE  4'h6
`define NFC_OP_ID          4'h7
`define NFC_OP_RESET       4'h8
// ctrl fields
`define NFC_CTRL_LAST_BIT  4
`define NFC_CTRL_DATA_BIT  5
// status byte fields
`define NFC_ST_OR_BIT      1
`define NFC_ST_D0_BIT      2
`define NFC_ST_D1_BIT      3
`define NFC_ST_RDY_BIT     6
// timing
`define NFC_T_STROBE_NS    25
`define NFC_ID_BYTES       5
`define NFC_ADDR_CYCLES    5
`define NFC_ROW_CYCLES     3
`endif

// file: verilog/nfc_host.v
// host sequencer driving a two-district nand flash over its pins
`timescale 1ns/1ps
`include "nfc_defines.vh"
module nfc_host #(
	parameter CLK_MHZ = 200
)(
	input  wire        clock,
	input  wire        rstn,
	input  wire [3:0]  addr,
	input  wire [31:0] wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [31:0] rdata,
	output reg         nand_ce_n,
	output reg         nand_cle,
	output reg         nand_ale,
	output reg         nand_we_n,
	output reg         read_strobe_n,
	output reg         nand_wp_n,
	output reg  [7:0]  nand_io_out,
	output reg         nand_io_oe,
	input  wire [7:0]  nand_io_in,
	input  wire        ready_busy_output
);
	// ***************************************************************
	// timing and states
	// ***************************************************************
	localparam STROBE_CYC = (`NFC_T_STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam [3:0] ST_IDLE = 4'h0;
	localparam [3:0] ST_CMD  = 4'h1;
	localparam [3:0] ST_ADR  = 4'h2;
	localparam [3:0] ST_DIN  = 4'h3;
	localparam [3:0] ST_DOUT = 4'h4;
	localparam [3:0] ST_WAIT = 4'h5;
	localparam [3:0] ST_NEXT = 4'h6;
	localparam [3:0] ST_IDRD = 4'h7;

	// ***************************************************************
	// registers
	// ***************************************************************
	reg [7:0]  ctrl_ff;
	reg [23:0] addr_a_ff;
	reg [23:0] addr_b_ff;
	reg [7:0]  wbyte_ff;
	reg        wbyte_vld_ff;
	reg [7:0]  rbyte_ff;
	reg        rbyte_vld_ff;
	reg [39:0] id_ff;
	reg [7:0]  dstat_ff;
	reg [15:0] count_ff;
	reg [15:0] left_ff;
	reg [3:0]  state_ff;
	reg [3:0]  step_ff;
	reg [2:0]  acnt_ff;
	reg [7:0]  tmr_ff;
	reg        busy_ff;
	reg        err_ff;
	reg        rb_s1_ff;
	reg        rb_s2_ff;
	reg [7:0]  io_s1_ff;
	reg [7:0]  io_s2_ff;
	reg [2:0]  idx_ff;
	reg        rb_seen_ff;

	wire [3:0] op = ctrl_ff[3:0];
	wire       last = ctrl_ff[`NFC_CTRL_LAST_BIT];
	wire       dual = (op == `NFC_OP_DUAL_PROG) ||
		(op == `NFC_OP_DUAL_COPY) || (op == `NFC_OP_DUAL_ERASE);
	// district is the block number's lowest bit (row bit 6)
	wire       dist_a = addr_a_ff[6];
	wire       dist_b = addr_b_ff[6];
	// one block per district and same page bits in dual program and dual copy
	wire       dual_ok = (dist_a != dist_b) &&
		(addr_a_ff[5:0] == addr_b_ff[5:0]);
	wire       rdy = rb_s2_ff;
	// first address of a sequence from addr_a, every later one from addr_b
	wire [23:0] cur_row = (step_ff != 4'h0) ? addr_b_ff : addr_a_ff;

	// ***************************************************************
	// pin synchronisers
	// ***************************************************************
	always @(posedge clock)
	begin
		if (!rstn)
		begin
			rb_s1_ff <= 1'b0;
			rb_s2_ff <= 1'b0;
			io_s1_ff <= 8'h00;
			io_s2_ff <= 8'h00;
		end
		else
		begin
			rb_s1_ff <= ready_busy_output;
			rb_s2_ff <= rb_s1_ff;
			io_s1_ff <= nand_io_in;
			io_s2_ff <= io_s1_ff;
		end
	end

	// ***************************************************************
	// command sequence lookup: step to command byte
	// ***************************************************************
	reg [7:0] seq_cmd;
	reg       seq_adr;
	reg       seq_row;
	reg       seq_din;
	reg       seq_end;
	always @*
	begin
		seq_cmd = `NFC_CMD_RESET;
		seq_adr = 1'b0;
		seq_row = 1'b0;
		seq_din = 1'b0;
		seq_end = 1'b0;
		case (op)
		`NFC_OP_PROG, `NFC_OP_COPY:
			case (step_ff)
			4'h0:
			begin
				seq_cmd = (op == `NFC_OP_COPY) ? `NFC_CMD_COPY_TGT :
					`NFC_CMD_SETUP;
				seq_adr = 1'b1;
				seq_din = ctrl_ff[`NFC_CTRL_DATA_BIT] ||
					(op == `NFC_OP_PROG);
			end
			default:
			begin
				seq_cmd = last ? `NFC_CMD_PROG : `NFC_CMD_CACHE;
				seq_end = 1'b1;
			end
			endcase
		`NFC_OP_DUAL_PROG, `NFC_OP_DUAL_COPY:
			case (step_ff)
			4'h0:
			begin
				seq_cmd = (op == `NFC_OP_DUAL_COPY) ?
					`NFC_CMD_COPY_TGT : `NFC_CMD_SETUP;
				seq_adr = 1'b1;
				seq_din = ctrl_ff[`NFC_CTRL_DATA_BIT] ||
					(op == `NFC_OP_DUAL_PROG);
			end
			4'h1:
			begin
				seq_cmd = `NFC_CMD_MULTI;
				seq_end = 1'b1;
			end
			4'h2:
			begin
				seq_cmd = (op == `NFC_OP_DUAL_COPY) ?
					`NFC_CMD_COPY_TGT : `NFC_CMD_SETUP2;
				seq_adr = 1'b1;
				seq_din = ctrl_ff[`NFC_CTRL_DATA_BIT] ||
					(op == `NFC_OP_DUAL_PROG);
			end
			default:
			begin
				seq_cmd = last ? `NFC_CMD_PROG : `NFC_CMD_CACHE;
				seq_end = 1'b1;
			end
			endcase
		`NFC_OP_ERASE, `NFC_OP_DUAL_ERASE:
			case (step_ff)
			4'h0:
			begin
				seq_cmd = `NFC_CMD_ERASE;
				seq_adr = 1'b1;
				seq_row = 1'b1;
			end
			4'h1:
			begin
				seq_cmd = (op == `NFC_OP_DUAL_ERASE) ? `NFC_CMD_ERASE :
					`NFC_CMD_ERASE_GO;
				seq_adr = (op == `NFC_OP_DUAL_ERASE);
				seq_row = 1'b1;
				seq_end = (op != `NFC_OP_DUAL_ERASE);
			end
			default:
			begin
				seq_cmd = `NFC_CMD_ERASE_GO;
				seq_end = 1'b1;
			end
			endcase
		`NFC_OP_ID:
		begin
			seq_cmd = `NFC_CMD_ID;
			seq_adr = 1'b1;
			seq_row = 1'b1;
			seq_end = 1'b1;
		end
		default: seq_end = 1'b1;
		endcase
	end

	// ***************************************************************
	// address byte for current cycle
	// ***************************************************************
	reg [7:0] adr_byte;
	// row byte index kept two bits wide so the column skip wraps cleanly
	wire [1:0] row_idx = seq_row ? acnt_ff[1:0] : acnt_ff[1:0] - 2'd2;
	always @*
	begin
		adr_byte = 8'h00;
		if (op == `NFC_OP_ID)
			adr_byte = 8'h00;
		else if (seq_row || acnt_ff >= 3'd2)
			adr_byte = cur_row[8 * row_idx +: 8];
	end

	wire [2:0] adr_n = (op == `NFC_OP_ID) ? 3'd1 :
		(seq_row ? 3'd`NFC_ROW_CYCLES : 3'd`NFC_ADDR_CYCLES);

	// ***************************************************************
	// main sequencer
	// ***************************************************************
	always @(posedge clock)
	begin
		if (!rstn)
		begin
			state_ff      <= ST_IDLE;
			step_ff       <= 4'h0;
			acnt_ff       <= 3'd0;
			tmr_ff        <= 8'h00;
			busy_ff       <= 1'b0;
			err_ff        <= 1'b0;
			nand_ce_n     <= 1'b1;
			nand_cle      <= 1'b0;
			nand_ale      <= 1'b0;
			nand_we_n     <= 1'b1;
			read_strobe_n <= 1'b1;
			nand_wp_n     <= 1'b0;
			nand_io_out   <= 8'h00;
			nand_io_oe    <= 1'b0;
			ctrl_ff       <= 8'h00;
			addr_a_ff     <= 24'h000000;
			addr_b_ff     <= 24'h000000;
			wbyte_ff      <= 8'h00;
			wbyte_vld_ff  <= 1'b0;
			rbyte_ff      <= 8'h00;
			rbyte_vld_ff  <= 1'b0;
			id_ff         <= 40'h0;
			dstat_ff      <= 8'h00;
			count_ff      <= 16'h0000;
			left_ff       <= 16'h0000;
			idx_ff        <= 3'd0;
			rb_seen_ff    <= 1'b0;
			rdata         <= 32'h0;
		end
		else
		begin
			// register port
			rdata <= 32'h0;
			if (rd)
				case (addr)
				`NFC_REG_CTRL:   rdata <= {24'h0, ctrl_ff};
				`NFC_REG_ADDR_A: rdata <= {8'h0, addr_a_ff};
				`NFC_REG_ADDR_B: rdata <= {8'h0, addr_b_ff};
				`NFC_REG_STATUS: rdata <= {26'h0, wbyte_vld_ff,
					rbyte_vld_ff, err_ff, rdy, !rdy, busy_ff};
				`NFC_REG_RDATA:  rdata <= {23'h0, rbyte_vld_ff, rbyte_ff};
				`NFC_REG_ID_LO:  rdata <= id_ff[31:0];
				`NFC_REG_ID_HI:  rdata <= {24'h0, id_ff[39:32]};
				`NFC_REG_DSTAT:  rdata <= {24'h0, dstat_ff};
				`NFC_REG_COUNT:  rdata <= {16'h0, count_ff};
				default:         rdata <= 32'h0;
				endcase
			if (rd && addr == `NFC_REG_RDATA)
				rbyte_vld_ff <= 1'b0;
			if (wr && addr == `NFC_REG_ADDR_A && !busy_ff)
				addr_a_ff <= wdata[23:0];
			if (wr && addr == `NFC_REG_ADDR_B && !busy_ff)
				addr_b_ff <= wdata[23:0];
			if (wr && addr == `NFC_REG_COUNT && !busy_ff)
				count_ff <= wdata[15:0];
			if (wr && addr == `NFC_REG_WDATA)
			begin
				wbyte_ff     <= wdata[7:0];
				wbyte_vld_ff <= 1'b1;
			end
			if (wr && addr == `NFC_REG_CTRL && !busy_ff)
			begin
				ctrl_ff <= wdata[7:0];
				err_ff  <= 1'b0;
				busy_ff    <= 1'b1;
				step_ff    <= 4'h0;
				state_ff   <= ST_CMD;
				tmr_ff     <= 8'h00;
				nand_ce_n  <= 1'b0;
				nand_wp_n  <= 1'b1;
			end
			case (state_ff)
			ST_IDLE: nand_io_oe <= 1'b0;
			ST_CMD:
			begin
				// dual requests with bad district pairing are refused
				if (dual && !dual_ok && op != `NFC_OP_DUAL_ERASE)
				begin
					err_ff    <= 1'b1;
					busy_ff   <= 1'b0;
					nand_ce_n <= 1'b1;
					state_ff  <= ST_IDLE;
				end
				// copy source row sits in addr_b, target shares its district
				else if ((op == `NFC_OP_DUAL_ERASE && dist_a == dist_b) ||
					(op == `NFC_OP_COPY && dist_a != dist_b))
				begin
					err_ff    <= 1'b1;
					busy_ff   <= 1'b0;
					nand_ce_n <= 1'b1;
					state_ff  <= ST_IDLE;
				end
				else if (tmr_ff == 8'h00)
				begin
					nand_cle    <= 1'b1;
					nand_io_out <= seq_cmd;
					nand_io_oe  <= 1'b1;
					nand_we_n   <= 1'b0;
					tmr_ff      <= 8'h01;
				end
				else if (tmr_ff == STROBE_CYC[7:0])
				begin
					nand_we_n <= 1'b1;
					tmr_ff    <= tmr_ff + 8'h01;
				end
				else if (tmr_ff > STROBE_CYC[7:0])
				begin
					nand_cle <= 1'b0;
					tmr_ff   <= 8'h00;
					acnt_ff  <= 3'd0;
					if (seq_adr)
						state_ff <= ST_ADR;
					else if (seq_end)
						state_ff <= ST_WAIT;
					else
						state_ff <= ST_NEXT;
				end
				else
					tmr_ff <= tmr_ff + 8'h01;
			end
			ST_ADR:
			begin
				if (tmr_ff == 8'h00)
				begin
					nand_ale    <= 1'b1;
					nand_io_out <= adr_byte;
					nand_we_n   <= 1'b0;
					tmr_ff      <= 8'h01;
				end
				else if (tmr_ff == STROBE_CYC[7:0])
				begin
					nand_we_n <= 1'b1;
					tmr_ff    <= tmr_ff + 8'h01;
				end
				else if (tmr_ff > STROBE_CYC[7:0])
				begin
					tmr_ff  <= 8'h00;
					acnt_ff <= acnt_ff + 3'd1;
					if (acnt_ff + 3'd1 == adr_n)
					begin
						nand_ale <= 1'b0;
						left_ff  <= count_ff;
						idx_ff   <= 3'd0;
						if (op == `NFC_OP_ID)
						begin
							nand_io_oe <= 1'b0;
							state_ff   <= ST_IDRD;
						end
						else if (seq_din && count_ff != 16'h0000)
							state_ff <= ST_DIN;
						else if (seq_end)
							state_ff <= ST_WAIT;
						else
							state_ff <= ST_NEXT;
					end
				end
				else
					tmr_ff <= tmr_ff + 8'h01;
			end
			ST_DIN:
			begin
				// stalls until software supplies the next byte
				if (tmr_ff == 8'h00 && wbyte_vld_ff)
				begin
					nand_io_out  <= wbyte_ff;
					nand_we_n    <= 1'b0;
					// a byte written in this very cycle stays pending
					if (!(wr && addr == `NFC_REG_WDATA))
						wbyte_vld_ff <= 1'b0;
					tmr_ff       <= 8'h01;
				end
				else if (tmr_ff == STROBE_CYC[7:0])
				begin
					nand_we_n <= 1'b1;
					tmr_ff    <= tmr_ff + 8'h01;
				end
				else if (tmr_ff > STROBE_CYC[7:0])
				begin
					tmr_ff  <= 8'h00;
					left_ff <= left_ff - 16'h0001;
					if (left_ff == 16'h0001)
						state_ff <= ST_NEXT;
				end
				else if (tmr_ff != 8'h00)
					tmr_ff <= tmr_ff + 8'h01;
			end
			ST_NEXT:
			begin
				step_ff  <= step_ff + 4'h1;
				tmr_ff   <= 8'h00;
				state_ff <= (seq_end) ? ST_WAIT : ST_CMD;
				if (op == `NFC_OP_PROG || op == `NFC_OP_COPY ||
					step_ff == 4'h0 || step_ff == 4'h2 || step_ff == 4'h3)
					state_ff <= ST_CMD;
			end
			ST_WAIT:
			begin
				// device busy after 11h, 15h, 10h, d0h or ffh
				nand_io_oe <= 1'b0;
				if (!rdy)
					rb_seen_ff <= 1'b1;
				if (rb_seen_ff && rdy)
				begin
					rb_seen_ff <= 1'b0;
					if (seq_cmd == `NFC_CMD_MULTI)
					begin
						step_ff  <= step_ff + 4'h1;
						state_ff <= ST_CMD;
					end
					else if (dual && op != `NFC_OP_ID)
					begin
						// collect district result with 71h
						ctrl_ff[3:0] <= `NFC_OP_ID;
						state_ff     <= ST_DOUT;
						tmr_ff       <= 8'h00;
					end
					else
					begin
						busy_ff   <= 1'b0;
						nand_ce_n <= 1'b1;
						state_ff  <= ST_IDLE;
					end
				end
			end
			ST_DOUT:
			begin
				// 71h then one status byte read back
				if (tmr_ff == 8'h00)
				begin
					nand_cle    <= 1'b1;
					nand_io_out <= `NFC_CMD_STAT_DIST;
					nand_io_oe  <= 1'b1;
					nand_we_n   <= 1'b0;
				end
				if (tmr_ff == STROBE_CYC[7:0])
				begin
					nand_we_n <= 1'b1;
				end
				// cle held one cycle past the rising strobe so 71h latches
				if (tmr_ff == STROBE_CYC[7:0] + 8'h01)
				begin
					nand_cle      <= 1'b0;
					nand_io_oe    <= 1'b0;
					read_strobe_n <= 1'b0;
				end
				if (tmr_ff == 3 * STROBE_CYC[7:0] + 8'h04)
				begin
					read_strobe_n <= 1'b1;
					dstat_ff      <= io_s2_ff;
					busy_ff       <= 1'b0;
					nand_ce_n     <= 1'b1;
					state_ff      <= ST_IDLE;
				end
				tmr_ff <= tmr_ff + 8'h01;
			end
			ST_IDRD:
			begin
				// five identification bytes read in turn
				if (tmr_ff == 8'h00)
					read_strobe_n <= 1'b0;
				if (tmr_ff == 2 * STROBE_CYC[7:0] + 8'h03)
				begin
					read_strobe_n <= 1'b1;
					id_ff[8 * idx_ff +: 8] <= io_s2_ff;
					rbyte_ff     <= io_s2_ff;
					rbyte_vld_ff <= 1'b1;
					idx_ff <= idx_ff + 3'd1;
					if (idx_ff == 3'd`NFC_ID_BYTES - 3'd1)
					begin
						busy_ff   <= 1'b0;
						nand_ce_n <= 1'b1;
						state_ff  <= ST_IDLE;
					end
				end
				tmr_ff <= (tmr_ff == 2 * STROBE_CYC[7:0] + 8'h04) ?
					8'h00 : tmr_ff + 8'h01;
			end
			default: state_ff <= ST_IDLE;
			endcase
		end
	end
endmodule
